// File: rtl/rri_ahb_slave.v
`timescale 1ns/1ps
// AHB-Lite single-word slave: writes have no wait state,
// reads have one wait state so hrdata is registered.
module rri_ahb_slave #(
  parameter AW = 8
)(
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire          hready,
  input  wire [31:0]   rd_data,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  output reg           wr_en,
  output reg  [AW-1:0] wr_addr,
  output reg           rd_pend,
  output reg  [AW-1:0] rd_addr
);

  wire take;

  assign take = hsel && htrans[1] && hready;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_en     <= 1'b0;
      wr_addr   <= {AW{1'b0}};
      rd_pend   <= 1'b0;
      rd_addr   <= {AW{1'b0}};
    end
    else
    begin
      wr_en <= take && hwrite;
      if (take)
      begin
        wr_addr <= haddr[AW-1:0];
        rd_addr <= haddr[AW-1:0];
      end
      if (take && !hwrite)
      begin
        rd_pend   <= 1'b1;
        hreadyout <= 1'b0;
      end
      else if (rd_pend)
      begin
        rd_pend   <= 1'b0;
        hrdata    <= rd_data;
        hreadyout <= 1'b1;
      end
    end
  end

endmodule

// File: rtl/rri_core.v
`timescale 1ns/1ps
`include "rri_map.vh"
module rri_core #(
  parameter AW = 8
)(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        por_bor_reset,
  input  wire        warm_reset,
  input  wire        wake_wdt,
  input  wire        wake_irq,
  input  wire        wake_irq_high,
  input  wire [7:0]  wake_flag_bits,
  input  wire        osc_frees_pa67,
  input  wire [7:0]  port_a_pins,
  output wire [20:0] pc_out,
  output wire [7:0]  port_a_latch_out,
  output wire [7:0]  port_a_dir_out
);

  // Return stack top and pointer
  reg [4:0]  stack_top_upper;
  reg [7:0]  stack_top_high;
  reg [7:0]  stack_top_low;
  reg [4:0]  stack_index;
  reg        stack_full;
  reg        stack_under;

  // Program counter and its latches
  reg [4:0]  pc_latch_upper;
  reg [7:0]  pc_latch_high;
  reg [20:0] pc;

  // Table access
  reg [5:0]  table_ptr_upper;
  reg [7:0]  table_ptr_high;
  reg [7:0]  table_ptr_low;
  reg [7:0]  table_latch;

  // Multiplier product
  reg [7:0]  product_high;
  reg [7:0]  product_low;

  // Interrupt control
  reg [7:0]  irq_control_main;
  reg [7:0]  irq_control_second;
  reg [7:0]  irq_control_third;

  // Indirect pointer and working register
  reg [3:0]  indirect_ptr0_high;
  reg [7:0]  indirect_ptr0_low;
  reg [7:0]  working_register;

  // Port A
  reg [7:0]  port_a_input;
  reg [7:0]  port_a_latch;
  reg [7:0]  port_a_direction;

  // Last event seen, one-hot
  reg [3:0]  reset_cause;

  // Register bus side
  wire          wr_en;
  wire [AW-1:0] wr_addr;
  wire          rd_pend;
  wire [AW-1:0] rd_addr;
  reg  [31:0]   rd_data;
  wire [7:0]    wd;
  wire          gie_any;
  wire [7:0]    wake_flags;
  reg  [7:0]    next_irq_main;

  assign wd = hwdata[7:0];
  assign pc_out = pc;
  assign port_a_latch_out = port_a_latch;
  assign port_a_dir_out = port_a_direction;
  assign gie_any = irq_control_main[`RRI_BIT_HIGH_PRIO_GLOBAL_IRQ_ENABLE] |
                   irq_control_main[`RRI_BIT_LOW_PRIO_GLOBAL_IRQ_ENABLE];
  // Wake-up flags; an empty set still marks bit 0
  assign wake_flags = (wake_flag_bits == 8'h00) ? `RRI_WAKE_DFLT
                                                : wake_flag_bits;

  // Port A bits 6 and 7 are forced low unless the pins are free
  function [7:0] pa_mask;
    input [7:0] v;
    input       freed;
    begin
      pa_mask = freed ? v : (v & `RRI_PA_LOW_MASK);
    end
  endfunction

  // Sequential advance for every wake-up that skips the vector
  function [20:0] pc_step;
    input [20:0] v;
    begin
      pc_step = v + `RRI_PC_STEP;
    end
  endfunction

  rri_ahb_slave #(
    .AW (AW)
  ) u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .rd_data   (rd_data),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .rd_pend   (rd_pend),
    .rd_addr   (rd_addr)
  );

  // Interrupt control value after this cycle's bus write
  always @*
  begin
    next_irq_main = irq_control_main;
    if (wr_en && wr_addr == `RRI_OFF_IRQ_MAIN)
      next_irq_main = wd;
  end

  // Read multiplexer; narrow fields are zero-extended
  always @*
  begin
    rd_data = 32'h00000000;
    case (rd_addr)
      `RRI_OFF_TOP_U:     rd_data[4:0] = stack_top_upper;
      `RRI_OFF_TOP_H:     rd_data[7:0] = stack_top_high;
      `RRI_OFF_TOP_L:     rd_data[7:0] = stack_top_low;
      `RRI_OFF_RETURN_STACK_POINTER:
        rd_data[7:0] = {stack_full, stack_under, 1'b0, stack_index};
      `RRI_OFF_PCLAT_U:   rd_data[4:0] = pc_latch_upper;
      `RRI_OFF_PCLAT_H:   rd_data[7:0] = pc_latch_high;
      `RRI_OFF_PC_LOW:    rd_data[7:0] = pc[7:0];
      `RRI_OFF_TBL_U:     rd_data[5:0] = table_ptr_upper;
      `RRI_OFF_TBL_H:     rd_data[7:0] = table_ptr_high;
      `RRI_OFF_TBL_L:     rd_data[7:0] = table_ptr_low;
      `RRI_OFF_TABLE_LATCH:    rd_data[7:0] = table_latch;
      `RRI_OFF_PROD_H:    rd_data[7:0] = product_high;
      `RRI_OFF_PROD_L:    rd_data[7:0] = product_low;
      `RRI_OFF_IRQ_MAIN:  rd_data[7:0] = irq_control_main;
      `RRI_OFF_IRQ_SEC:   rd_data[7:0] = irq_control_second;
      `RRI_OFF_IRQ_THIRD: rd_data[7:0] = irq_control_third;
      `RRI_OFF_IND0_H:    rd_data[3:0] = indirect_ptr0_high;
      `RRI_OFF_IND0_L:    rd_data[7:0] = indirect_ptr0_low;
      `RRI_OFF_WORK:      rd_data[7:0] = working_register;
      `RRI_OFF_PA_IN:
        rd_data[7:0] = pa_mask(port_a_input, osc_frees_pa67);
      `RRI_OFF_PA_LAT:
        rd_data[7:0] = pa_mask(port_a_latch, osc_frees_pa67);
      `RRI_OFF_PA_DIR:
        rd_data[7:0] = pa_mask(port_a_direction, osc_frees_pa67);
      `RRI_OFF_PC_FULL:   rd_data[20:0] = pc;
      `RRI_OFF_CAUSE:     rd_data[3:0] = reset_cause;
      default:            rd_data = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // Hard reset loads every register, unknown-valued ones too: all zero except irq_control_second, irq_control_third and reset_cause
      stack_top_upper    <= 5'h00;
      stack_top_high     <= `RRI_RST_ZERO;
      stack_top_low      <= `RRI_RST_ZERO;
      stack_index        <= 5'h00;
      stack_full         <= 1'b0;
      stack_under        <= 1'b0;
      pc_latch_upper     <= 5'h00;
      pc_latch_high      <= `RRI_RST_ZERO;
      pc                 <= 21'h000000;
      table_ptr_upper    <= 6'h00;
      table_ptr_high     <= `RRI_RST_ZERO;
      table_ptr_low      <= `RRI_RST_ZERO;
      table_latch        <= `RRI_RST_ZERO;
      product_high       <= `RRI_RST_ZERO;
      product_low        <= `RRI_RST_ZERO;
      irq_control_main   <= `RRI_RST_ZERO;
      irq_control_second <= `RRI_RST_IRQ_SEC;
      irq_control_third  <= `RRI_RST_IRQ_THIRD;
      indirect_ptr0_high <= 4'h0;
      indirect_ptr0_low  <= `RRI_RST_ZERO;
      working_register   <= `RRI_RST_ZERO;
      port_a_input       <= `RRI_RST_ZERO;
      port_a_latch       <= `RRI_RST_ZERO;
      port_a_direction   <= `RRI_RST_ZERO;
      reset_cause        <= 4'h1;
    end
    else
    begin
      port_a_input <= pa_mask(port_a_pins, osc_frees_pa67);
      // Reading the PC low byte refreshes the upper latches
      if (rd_pend && rd_addr == `RRI_OFF_PC_LOW)
      begin
        pc_latch_upper <= pc[20:16];
        pc_latch_high  <= pc[15:8];
      end
      // Software writes; the events below take priority
      if (wr_en)
      begin
        case (wr_addr)
          `RRI_OFF_TOP_U:     stack_top_upper <= wd[4:0];
          `RRI_OFF_TOP_H:     stack_top_high <= wd;
          `RRI_OFF_TOP_L:     stack_top_low <= wd;
          `RRI_OFF_RETURN_STACK_POINTER:
          begin
            // Overflow and underflow flags can only be cleared
            stack_index <= wd[4:0];
            stack_full  <= stack_full & wd[`RRI_BIT_STKFUL];
            stack_under <= stack_under & wd[`RRI_BIT_STKUNF];
          end
          `RRI_OFF_PCLAT_U:   pc_latch_upper <= wd[4:0];
          `RRI_OFF_PCLAT_H:   pc_latch_high <= wd;
          `RRI_OFF_PC_LOW:    pc <= {pc_latch_upper, pc_latch_high, wd};
          `RRI_OFF_TBL_U:     table_ptr_upper <= wd[5:0];
          `RRI_OFF_TBL_H:     table_ptr_high <= wd;
          `RRI_OFF_TBL_L:     table_ptr_low <= wd;
          `RRI_OFF_TABLE_LATCH:    table_latch <= wd;
          `RRI_OFF_PROD_H:    product_high <= wd;
          `RRI_OFF_PROD_L:    product_low <= wd;
          `RRI_OFF_IRQ_MAIN:  irq_control_main <= wd;
          `RRI_OFF_IRQ_SEC:   irq_control_second <= wd;
          `RRI_OFF_IRQ_THIRD: irq_control_third <= wd;
          `RRI_OFF_IND0_H:    indirect_ptr0_high <= wd[3:0];
          `RRI_OFF_IND0_L:    indirect_ptr0_low <= wd;
          `RRI_OFF_WORK:      working_register <= wd;
          `RRI_OFF_PA_LAT:
            port_a_latch <= pa_mask(wd, osc_frees_pa67);
          `RRI_OFF_PA_DIR:
            port_a_direction <= pa_mask(wd, osc_frees_pa67);
          default:
          begin
          end
        endcase
      end
      // Pins taken by the oscillator: bits 7:6 stay clear
      if (!osc_frees_pa67)
      begin
        port_a_latch[7:6]     <= 2'b00;
        port_a_direction[7:6] <= 2'b00;
      end
      if (por_bor_reset)
      begin
        // Power-on class; unknown-valued registers are left as they are
        stack_top_upper    <= 5'h00;
        stack_top_high     <= `RRI_RST_ZERO;
        stack_top_low      <= `RRI_RST_ZERO;
        stack_index        <= 5'h00;
        pc_latch_upper     <= 5'h00;
        pc_latch_high      <= `RRI_RST_ZERO;
        pc                 <= 21'h000000;
        table_ptr_upper    <= 6'h00;
        table_ptr_high     <= `RRI_RST_ZERO;
        table_ptr_low      <= `RRI_RST_ZERO;
        table_latch        <= `RRI_RST_ZERO;
        irq_control_main   <= {7'h00, irq_control_main[0]};
        irq_control_second <= `RRI_RST_IRQ_SEC;
        irq_control_third  <= `RRI_RST_IRQ_THIRD;
        reset_cause        <= 4'h1;
      end
      else if (warm_reset)
      begin
        // One value set for every warm reset source
        stack_top_upper    <= 5'h00;
        stack_top_high     <= `RRI_RST_ZERO;
        stack_top_low      <= `RRI_RST_ZERO;
        stack_index        <= 5'h00;
        stack_full         <= 1'b0;
        stack_under        <= 1'b0;
        pc_latch_upper     <= 5'h00;
        pc_latch_high      <= `RRI_RST_ZERO;
        pc                 <= 21'h000000;
        table_ptr_upper    <= 6'h00;
        table_ptr_high     <= `RRI_RST_ZERO;
        table_ptr_low      <= `RRI_RST_ZERO;
        table_latch        <= `RRI_RST_ZERO;
        irq_control_main   <= {7'h00, irq_control_main[0]};
        irq_control_second <= `RRI_RST_IRQ_SEC;
        irq_control_third  <= `RRI_RST_IRQ_THIRD;
        reset_cause        <= 4'h2;
      end
      else if (wake_irq)
      begin
        // Only stack, PC, interrupt flags and reset_cause move on a wake-up
        irq_control_main <= next_irq_main | wake_flags;
        reset_cause      <= 4'h8;
        // Push the current PC, then jump to the vector
        if (gie_any)
        begin
          stack_top_upper <= pc[20:16];
          stack_top_high  <= pc[15:8];
          stack_top_low   <= pc[7:0];
          if (stack_index == `RRI_SP_MAX)
            stack_full <= 1'b1;
          else
            stack_index <= stack_index + 5'h01;
          if (wake_irq_high)
            pc <= `RRI_VEC_HIGH;
          else
            pc <= `RRI_VEC_LOW;
        end
        else
        begin
          // No enable set: resume after the sleep
          pc <= pc_step(pc);
        end
      end
      else if (wake_wdt)
      begin
        // Watchdog wake-up resumes at the next instruction
        pc          <= pc_step(pc);
        reset_cause <= 4'h4;
      end
    end
  end

endmodule

// File: rtl/rri_map.vh
`ifndef RRI_MAP_VH
`define RRI_MAP_VH

// Byte offsets on the register bus
`define RRI_OFF_TOP_U     8'h00
`define RRI_OFF_TOP_H     8'h04
`define RRI_OFF_TOP_L     8'h08
`define RRI_OFF_RETURN_STACK_POINTER    8'h0c
`define RRI_OFF_PCLAT_U   8'h10
`define RRI_OFF_PCLAT_H   8'h14
`define RRI_OFF_PC_LOW    8'h18
`define RRI_OFF_TBL_U     8'h1c
`define RRI_OFF_TBL_H     8'h20
`define RRI_OFF_TBL_L     8'h24
`define RRI_OFF_TABLE_LATCH    8'h28
`define RRI_OFF_PROD_H    8'h2c
`define RRI_OFF_PROD_L    8'h30
`define RRI_OFF_IRQ_MAIN  8'h34
`define RRI_OFF_IRQ_SEC   8'h38
`define RRI_OFF_IRQ_THIRD 8'h3c
`define RRI_OFF_IND0_H    8'h40
`define RRI_OFF_IND0_L    8'h44
`define RRI_OFF_WORK      8'h48
`define RRI_OFF_PA_IN     8'h4c
`define RRI_OFF_PA_LAT    8'h50
`define RRI_OFF_PA_DIR    8'h54
`define RRI_OFF_PC_FULL   8'h58
`define RRI_OFF_CAUSE     8'h5c

// Reset values
`define RRI_RST_ZERO      8'h00
`define RRI_RST_IRQ_SEC   8'hff
`define RRI_RST_IRQ_THIRD 8'hc0

// Field positions
`define RRI_BIT_HIGH_PRIO_GLOBAL_IRQ_ENABLE      7
`define RRI_BIT_LOW_PRIO_GLOBAL_IRQ_ENABLE      6
`define RRI_BIT_STKFUL    7
`define RRI_BIT_STKUNF    6
`define RRI_BIT_CS_POR    0
`define RRI_BIT_CS_WARM   1
`define RRI_BIT_CS_WDT    2
`define RRI_BIT_CS_IRQ    3

// Interrupt vectors, PC step, stack limit and masks
`define RRI_VEC_HIGH      21'h000008
`define RRI_VEC_LOW       21'h000018
`define RRI_PC_STEP       21'h000002
`define RRI_SP_MAX        5'h1f
`define RRI_PA_LOW_MASK   8'h3f
`define RRI_WAKE_DFLT     8'h01

`endif

// File: verification/rri_chk_properties.sv
`timescale 1ns/1ps
`include "rri_map.vh"
module rri_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        por_bor_reset,
  input wire        warm_reset,
  input wire        wake_wdt,
  input wire        wake_irq,
  input wire        wake_irq_high,
  input wire        osc_frees_pa67,
  input wire [20:0] pc_out,
  input wire [7:0]  port_a_latch_out,
  input wire [7:0]  port_a_dir_out
);
  wire ev = por_bor_reset | warm_reset | wake_wdt | wake_irq;
  wire hot = por_bor_reset | warm_reset;
  wire take = hsel & htrans[1] & hready;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_por_pc_zero: assert property (por_bor_reset |=> pc_out == 21'h0)
    else $error("pc not cleared by power reset");
  chk_warm_pc_zero: assert property (warm_reset |=> pc_out == 21'h0)
    else $error("pc not cleared by warm reset");
  chk_wdt_pc_step: assert property (wake_wdt && !wake_irq && !hot |=>
    pc_out == $past(pc_out) + `RRI_PC_STEP)
    else $error("pc not stepped on watchdog wake");
  chk_irq_pc_load: assert property (wake_irq && !hot |=>
    pc_out == ($past(wake_irq_high) ? `RRI_VEC_HIGH : `RRI_VEC_LOW) ||
    pc_out == $past(pc_out) + `RRI_PC_STEP)
    else $error("pc wrong after interrupt wake");
  chk_pc_hold: assert property (!hsel ##1 (!hsel && !ev) |=>
    pc_out == $past(pc_out))
    else $error("pc changed with no cause");
  chk_pa_latch_hi: assert property (!osc_frees_pa67 [*2] |->
    port_a_latch_out[7:6] == 2'b00)
    else $error("latch bits 7:6 set while pins taken");
  chk_pa_dir_hi: assert property (!osc_frees_pa67 [*2] |->
    port_a_dir_out[7:6] == 2'b00)
    else $error("direction bits 7:6 set while pins taken");

  cover property (wake_irq && wake_irq_high);
  cover property (warm_reset);
  cover property (take && !hwrite);
endmodule

bind rri_core rri_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .por_bor_reset(por_bor_reset), .warm_reset(warm_reset),
  .wake_wdt(wake_wdt), .wake_irq(wake_irq), .wake_irq_high(wake_irq_high),
  .osc_frees_pa67(osc_frees_pa67), .pc_out(pc_out),
  .port_a_latch_out(port_a_latch_out), .port_a_dir_out(port_a_dir_out)
);

// File: verification/tb.sv
`timescale 1ns/1ps
`include "rri_map.vh"
module tb;
  logic        hclk, hresetn, hsel, hwrite, por, warm, wwdt, wirq;
  logic        wirqh, osc, hreadyout, hresp, rdy_s;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  flags, pins, lat_out, dir_out;
  logic [20:0] pc_out;
  logic [31:0] haddr, hwdata, hrdata, rd_s;
  int          fail_count, checked;

  rri_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .por_bor_reset(por), .warm_reset(warm),
    .wake_wdt(wwdt), .wake_irq(wirq), .wake_irq_high(wirqh),
    .wake_flag_bits(flags), .osc_frees_pa67(osc), .port_a_pins(pins),
    .pc_out(pc_out), .port_a_latch_out(lat_out), .port_a_dir_out(dir_out)
  );

  // Outputs are registered, so the mid-cycle value is the one seen at the edge
  always @(negedge hclk)
  begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end

  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        fail_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task bus(input bit w, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (rdy_s !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      r = rd_s;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task rd(input [7:0] a, input [31:0] e);
    logic [31:0] r;
    begin
      bus(1'b0, a, 32'h0, r);
      cmp(r, e);
    end
  endtask

  task pulse(input int k);
    begin
      case (k)
        0: por <= 1'b1;
        1: warm <= 1'b1;
        2: wwdt <= 1'b1;
        default: wirq <= 1'b1;
      endcase
      @(posedge hclk);
      {por, warm, wwdt, wirq} <= 4'h0;
      @(posedge hclk);
    end
  endtask

  task t_reset_vals;
    begin
      rd(`RRI_OFF_TOP_U, 32'h0);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h0);
      rd(`RRI_OFF_TBL_U, 32'h0);
      rd(`RRI_OFF_IRQ_SEC, 32'hff);
      rd(`RRI_OFF_IRQ_THIRD, 32'hc0);
      rd(8'h80, 32'h0);
      wr(8'h80, 32'hffffffff);
      rd(8'h80, 32'h0);
      wr(`RRI_OFF_TOP_U, 32'hffffffff);
      rd(`RRI_OFF_TOP_U, 32'h1f);
      wr(`RRI_OFF_TBL_U, 32'hffffffff);
      rd(`RRI_OFF_TBL_U, 32'h3f);
      wr(`RRI_OFF_RETURN_STACK_POINTER, 32'hffffffff);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h1f);
      wr(`RRI_OFF_IND0_H, 32'hffffffff);
      rd(`RRI_OFF_IND0_H, 32'h0f);
    end
  endtask

  task t_resets;
    int k;
    begin
      for (k = 0; k < 2; k++)
      begin
        wr(`RRI_OFF_TBL_L, 32'h5a);
        wr(`RRI_OFF_IRQ_SEC, 32'h0);
        wr(`RRI_OFF_WORK, 32'h33);
        wr(`RRI_OFF_PC_LOW, 32'h34);
        pulse(k);
        cmp({11'h0, pc_out}, 32'h0);
        rd(`RRI_OFF_TBL_L, 32'h0);
        rd(`RRI_OFF_IRQ_SEC, 32'hff);
        rd(`RRI_OFF_TOP_U, 32'h0);
        rd(`RRI_OFF_WORK, 32'h33);
        rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h0);
        rd(`RRI_OFF_CAUSE, 32'h1 << k);
      end
    end
  endtask

  task t_wakes;
    begin
      wr(`RRI_OFF_PCLAT_U, 32'h01);
      wr(`RRI_OFF_PCLAT_H, 32'h12);
      wr(`RRI_OFF_PC_LOW, 32'h34);
      wr(`RRI_OFF_TBL_L, 32'h5a);
      pulse(2);
      cmp({11'h0, pc_out}, 32'h011236);
      rd(`RRI_OFF_CAUSE, 32'h4);
      rd(`RRI_OFF_TBL_L, 32'h5a);
      wirqh <= 1'b1;
      flags <= 8'h04;
      wr(`RRI_OFF_IRQ_MAIN, 32'h80);
      pulse(3);
      cmp({11'h0, pc_out}, 32'h8);
      rd(`RRI_OFF_PC_FULL, 32'h8);
      rd(`RRI_OFF_TOP_U, 32'h01);
      rd(`RRI_OFF_TOP_H, 32'h12);
      rd(`RRI_OFF_TOP_L, 32'h36);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h01);
      rd(`RRI_OFF_IRQ_MAIN, 32'h84);
      rd(`RRI_OFF_TBL_L, 32'h5a);
      wirqh <= 1'b0;
      wr(`RRI_OFF_IRQ_MAIN, 32'h40);
      pulse(3);
      cmp({11'h0, pc_out}, 32'h18);
      rd(`RRI_OFF_TOP_L, 32'h08);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h02);
      flags <= 8'h00;
      wr(`RRI_OFF_IRQ_MAIN, 32'h00);
      pulse(3);
      cmp({11'h0, pc_out}, 32'h1a);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h02);
      rd(`RRI_OFF_IRQ_MAIN, 32'h01);
      wr(`RRI_OFF_RETURN_STACK_POINTER, 32'h1f);
      wr(`RRI_OFF_IRQ_MAIN, 32'h80);
      pulse(3);
      cmp({11'h0, pc_out}, 32'h18);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h9f);
      rd(`RRI_OFF_TOP_L, 32'h1a);
      wr(`RRI_OFF_RETURN_STACK_POINTER, 32'h00);
      rd(`RRI_OFF_RETURN_STACK_POINTER, 32'h00);
    end
  endtask

  task t_port_a;
    begin
      wr(`RRI_OFF_PA_LAT, 32'hff);
      wr(`RRI_OFF_PA_DIR, 32'hff);
      rd(`RRI_OFF_PA_LAT, 32'h3f);
      rd(`RRI_OFF_PA_DIR, 32'h3f);
      rd(`RRI_OFF_PA_IN, 32'h3f);
      osc <= 1'b1;
      pins <= 8'hc5;
      wr(`RRI_OFF_PA_LAT, 32'hff);
      wr(`RRI_OFF_PA_DIR, 32'hff);
      rd(`RRI_OFF_PA_LAT, 32'hff);
      rd(`RRI_OFF_PA_IN, 32'hc5);
      osc <= 1'b0;
      repeat (3) @(posedge hclk);
      cmp({24'h0, lat_out}, 32'h3f);
      cmp({24'h0, dir_out}, 32'h3f);
      rd(`RRI_OFF_PA_IN, 32'h05);
    end
  endtask

  task final_report;
    begin
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial
  begin
    #100000;
    fail_count++;
    final_report;
  end

  initial
  begin
    {hresetn, hsel, hwrite, por, warm, wwdt, wirq, wirqh, osc} = 9'h0;
    {htrans, haddr, hwdata, flags} = 74'h0;
    hsize = 3'h2;
    pins = 8'hff;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_vals;
    t_resets;
    t_wakes;
    t_port_a;
    final_report;
  end
endmodule
